// File: src/tape_xport_map.svh
// Purpose: constants for the paper tape transport control block
// Assumes: 250 MHz system clock
// Notes:   times in ns, counts derived from them
`ifndef TAPE_XPORT_MAP_SVH
`define TAPE_XPORT_MAP_SVH
`define CLK_PERIOD_NS    4
`define STROBE_WIDTH_NS  35000
`define STROBE_CYCLES    (`STROBE_WIDTH_NS / `CLK_PERIOD_NS)
`define WIND_RAMP_STEP   256
`define WIND_MAG_W       8
`define ARM_POS_W        8
`define ARM_NULL_HALF    8
`define CHAN_COUNT       8
`endif

// File: src/tape_xport_pkg.sv
// Purpose: types for the paper tape transport control block
// Assumes: nothing
// Notes:   drive requests are decoded from these states and from the wind pin
package tape_xport_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_RUN   = 3'b010,
		ST_BRAKE = 3'b100
	} run_state_t;
endpackage

// File: src/tape_xport_ctrl.sv
// Purpose: run state, capstan drive gating, strobe, reel drive for tape transport
// Assumes: all pin inputs asynchronous to clk_sys
// Notes:   analog servos live outside; this block emits requests and magnitudes
`include "tape_xport_map.svh"

module tape_xport_ctrl
	import tape_xport_pkg::*;
#(
	parameter int STROBE_CYCLES = `STROBE_CYCLES,   // Strobe width in clocks
	parameter int RAMP_STEP     = `WIND_RAMP_STEP,  // Clocks per wind ramp step
	parameter int BRAKE_CYCLES  = 1024              // Brake command hold time
) (
	input  wire logic                      clk_sys,        // System clock
	input  wire logic                      rst,            // Sync reset, high
	input  wire logic                      start_in,       // Start pulse pin
	input  wire logic                      stop_in,        // Stop pulse pin
	input  wire logic                      fwd_in,         // Forward level pin
	input  wire logic                      rev_in,         // Reverse level pin
	input  wire logic                      wind_in,        // Wind level pin
	input  wire logic                      tape_absent_sw, // No-tape switch
	input  wire logic                      arm_limit_sw,   // Either arm limit
	input  wire logic                      spooler_mode,   // High: reader and spooler
	input  wire logic [`CHAN_COUNT-1:0]    hole_in,        // Hole sensors
	input  wire logic                      sprocket_in,    // Sprocket sensor
	input  wire logic [`ARM_POS_W-1:0]     arm_pos_l,      // Left arm, signed
	input  wire logic [`ARM_POS_W-1:0]     arm_pos_r,      // Right arm, signed
	output logic                           adv_req,        // Left-to-right drive
	output logic                           rev_req,        // Right-to-left drive
	output logic                           brake_cmd,      // Active braking
	output logic [`WIND_MAG_W-1:0]         wind_mag,       // Wind drive magnitude
	output logic                           tape_absent,    // No-tape to system
	output logic [`CHAN_COUNT-1:0]         chan_out,       // Channel levels
	output logic                           sprocket_out,   // Sprocket level
	output logic                           strobe_out,     // Gated strobe pulse
	output logic [1:0]                     reel_en,        // Reel drive on, [0] left
	output logic [1:0]                     reel_dir,       // Reel direction, 1 = positive
	output logic [2*(`ARM_POS_W-1)-1:0]    reel_speed,     // Reel speed magnitudes
	output logic                           running         // Run state
);
	// Eight single pins, then channels, then both arm positions
	localparam int NSYNC = 8 + `CHAN_COUNT + 2 * `ARM_POS_W;

	// Two-stage synchroniser on every pin except spooler_mode
	logic [NSYNC-1:0] sync1_r, sync2_r;
	wire  [NSYNC-1:0] pins = {arm_pos_r, arm_pos_l, hole_in, sprocket_in, start_in, stop_in,
				  fwd_in, rev_in, wind_in, tape_absent_sw, arm_limit_sw};
	always_ff @(posedge clk_sys) begin
		sync1_r <= pins;
		sync2_r <= sync1_r;
	end
	wire limit_s    = sync2_r[0];
	wire absent_s   = sync2_r[1];
	wire wind_s     = sync2_r[2];
	wire rev_s      = sync2_r[3];
	wire fwd_s      = sync2_r[4];
	wire stop_s     = sync2_r[5];
	wire start_s    = sync2_r[6];
	wire sprocket_s = sync2_r[7];
	wire [`CHAN_COUNT-1:0] hole_s = sync2_r[8 +: `CHAN_COUNT];
	wire [`ARM_POS_W-1:0]  pos_l  = sync2_r[8 + `CHAN_COUNT +: `ARM_POS_W];
	wire [`ARM_POS_W-1:0]  pos_r  = sync2_r[8 + `CHAN_COUNT + `ARM_POS_W +: `ARM_POS_W];

	logic start_d_r, stop_d_r, sprocket_d_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			start_d_r    <= 1'b0;
			stop_d_r     <= 1'b0;
			sprocket_d_r <= 1'b0;
		end else begin
			start_d_r    <= start_s;
			stop_d_r     <= stop_s;
			sprocket_d_r <= sprocket_s;
		end
	end
	wire start_edge = start_s & ~start_d_r;
	wire stop_edge  = stop_s & ~stop_d_r;
	wire absent_act = absent_s & spooler_mode;
	wire halt       = stop_edge | limit_s;

	// Run state; stop wins over a coincident start
	run_state_t state_r, state_nxt;
	logic [$clog2(BRAKE_CYCLES+1)-1:0] brake_cnt_r;
	wire brake_done = (brake_cnt_r == '0);
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:  if (start_edge && !halt) state_nxt = ST_RUN;
			ST_RUN:   if (halt) state_nxt = ST_BRAKE;
			ST_BRAKE: begin
				if (start_edge && !halt) state_nxt = ST_RUN;
				else if (brake_done) state_nxt = ST_IDLE;
			end
			default:  state_nxt = ST_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (rst) state_r <= ST_IDLE;
		else state_r <= state_nxt;
	end
	always_ff @(posedge clk_sys) begin
		if (rst || state_nxt != ST_BRAKE) brake_cnt_r <= ($clog2(BRAKE_CYCLES+1))'(BRAKE_CYCLES - 1);
		else if (!brake_done) brake_cnt_r <= brake_cnt_r - 1'b1;
	end

	// Direction decode: both or neither means none
	wire dir_fwd = fwd_s & ~rev_s;
	wire dir_rev = rev_s & ~fwd_s;
	wire run_on  = (state_r == ST_RUN);
	wire wind_on = wind_s & ~limit_s;
	wire drive_ok = ~absent_act;

	// Wind ramp; the slope lets the reel servos keep up
	logic [$clog2(RAMP_STEP+1)-1:0] ramp_cnt_r;
	logic [`WIND_MAG_W-1:0]         wind_mag_r;
	wire ramp_tick = (ramp_cnt_r == '0);
	always_ff @(posedge clk_sys) begin
		if (rst || !wind_on) begin
			ramp_cnt_r <= ($clog2(RAMP_STEP+1))'(RAMP_STEP - 1);
			wind_mag_r <= '0;
		end else begin
			ramp_cnt_r <= ramp_tick ? ($clog2(RAMP_STEP+1))'(RAMP_STEP - 1) : ramp_cnt_r - 1'b1;
			if (ramp_tick && wind_mag_r != '1) wind_mag_r <= wind_mag_r + 1'b1;
		end
	end

	// Registered drive outputs
	logic adv_r, rev_r, brake_r, absent_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			adv_r    <= 1'b0;
			rev_r    <= 1'b0;
			brake_r  <= 1'b0;
			absent_r <= 1'b0;
		end else begin
			adv_r    <= drive_ok & dir_fwd & (run_on | wind_on);
			rev_r    <= drive_ok & dir_rev & (run_on | wind_on);
			brake_r  <= (state_r == ST_BRAKE) & ~wind_on;
			absent_r <= absent_act;
		end
	end
	assign adv_req     = adv_r;
	assign rev_req     = rev_r;
	assign brake_cmd   = brake_r;
	assign tape_absent = absent_r;
	assign wind_mag    = wind_mag_r;
	assign running     = run_on;

	// Data levels
	logic [`CHAN_COUNT-1:0] chan_r;
	logic                   sprk_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			chan_r <= '0;
			sprk_r <= 1'b0;
		end else begin
			chan_r <= hole_s;
			sprk_r <= sprocket_s;
		end
	end
	assign chan_out     = chan_r;
	assign sprocket_out = sprk_r;

	// One-shot strobe; not retriggered while active
	logic [$clog2(STROBE_CYCLES+1)-1:0] strb_cnt_r;
	logic                               strb_r;
	wire sprk_rise = sprocket_s & ~sprocket_d_r;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			strb_cnt_r <= '0;
			strb_r     <= 1'b0;
		end else if (strb_cnt_r != '0) begin
			strb_cnt_r <= strb_cnt_r - 1'b1;
			strb_r     <= (strb_cnt_r != 1) & run_on;
		end else if (sprk_rise) begin
			strb_cnt_r <= ($clog2(STROBE_CYCLES+1))'(STROBE_CYCLES);
			strb_r     <= run_on;
		end else begin
			strb_r <= 1'b0;
		end
	end
	assign strobe_out = strb_r;

	// Reel drives, one per arm
	wire [2*`ARM_POS_W-1:0] pos_both = {pos_r, pos_l};
	logic [1:0]                  reel_en_r, reel_dir_r;
	logic [2*(`ARM_POS_W-1)-1:0] reel_spd_r;
	for (genvar g = 0; g < 2; g++) begin : g_reel
		wire [`ARM_POS_W-1:0]   p   = pos_both[g*`ARM_POS_W +: `ARM_POS_W];
		wire                    neg = p[`ARM_POS_W-1];
		wire [`ARM_POS_W-1:0]   mag = neg ? (~p + 1'b1) : p;
		wire [`ARM_POS_W-2:0]   m   = mag[`ARM_POS_W-2:0];
		wire                    out = (mag > (`ARM_POS_W)'(`ARM_NULL_HALF));
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				reel_en_r[g]                           <= 1'b0;
				reel_dir_r[g]                          <= 1'b0;
				reel_spd_r[g*(`ARM_POS_W-1) +: `ARM_POS_W-1] <= '0;
			end else begin
				reel_en_r[g]  <= out & spooler_mode & ~absent_s;
				reel_dir_r[g] <= ~neg;
				reel_spd_r[g*(`ARM_POS_W-1) +: `ARM_POS_W-1] <= (out & spooler_mode & ~absent_s) ? m : '0;
			end
		end
	end
	assign reel_en    = reel_en_r;
	assign reel_dir   = reel_dir_r;
	assign reel_speed = reel_spd_r;
endmodule

// File: bench/tape_xport_chk.sv
// Purpose: port checker for tape_xport_ctrl
// Assumes: one clock, sync reset
// Notes:   strobe length held in a counter
module tape_xport_chk #(parameter int STROBE_CYCLES = 20) (
	input wire logic       clk_sys,     // Clock
	input wire logic       rst,         // Reset
	input wire logic       start_in,    // Start pin
	input wire logic       adv_req,     // Advance
	input wire logic       rev_req,     // Reverse
	input wire logic       brake_cmd,   // Brake
	input wire logic [7:0] wind_mag,    // Wind level
	input wire logic       tape_absent, // No tape
	input wire logic       strobe_out,  // Strobe
	input wire logic       running      // Run state
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	int strb_cnt;
	always_ff @(posedge clk_sys)
		strb_cnt <= (rst || !strobe_out) ? 0 : strb_cnt + 1;
	chk_dir_excl: assert property (!(adv_req && rev_req)) else $error("both drives high");
	chk_start_run: assert property ($rose(running) |-> $past(start_in, 2)) else $error("run without start");
	chk_stop_brake: assert property ($fell(running) |=> brake_cmd && !adv_req && !rev_req) else $error("no brake");
	chk_brake_idle: assert property (brake_cmd |-> !running) else $error("brake while running");
	chk_strobe_gate: assert property (strobe_out |-> running || $past(running)) else $error("strobe when idle");
	chk_strobe_len: assert property (strobe_out |-> strb_cnt < STROBE_CYCLES) else $error("strobe too long");
	chk_absent_kill: assert property (tape_absent && $past(tape_absent) |-> !adv_req && !rev_req)
		else $error("drive with no tape");
	chk_wind_ramp: assert property ($changed(wind_mag) |-> wind_mag == 8'h00 || wind_mag == $past(wind_mag) + 8'h01)
		else $error("wind step");
endmodule
bind tape_xport_ctrl tape_xport_chk #(.STROBE_CYCLES(STROBE_CYCLES)) i_tape_xport_chk (.clk_sys, .rst, .start_in,
	.adv_req, .rev_req, .brake_cmd, .wind_mag, .tape_absent, .strobe_out, .running);

// File: bench/sys_model.sv
// Purpose: external controller issuing start and stop pulses
// Assumes: pins change 1 ns after clk_sys rise
// Notes:   loop_stop returns the sprocket level as a stop
module sys_model (
	input wire logic clk_sys,      // Clock
	input wire logic sprocket_out, // From block
	input wire logic loop_stop,    // Loop enable
	output logic     start_in,     // Start pin
	output logic     stop_in       // Stop pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic stop_r;
	assign stop_in = stop_r || (loop_stop && sprocket_out);
	initial {start_in, stop_r} = 2'b00;
	// Pulse held 3 clocks, then 3 low, so the synchroniser sees each one
	task automatic pulse(input logic is_stop);
		@(posedge clk_sys);
		#1 {start_in, stop_r} = {!is_stop, is_stop};
		repeat (3) @(posedge clk_sys);
		#1 {start_in, stop_r} = 2'b00;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench for tape_xport_ctrl
// Assumes: inputs change 1 ns after clk_sys rise
// Notes:   short strobe, ramp and brake counts keep the run brief
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STRB = 20;
	logic        clk_sys = 1'b0, rst = 1'b1, fwd_in = 1'b0, rev_in = 1'b0, wind_in = 1'b0, loop_stop = 1'b0;
	logic        tape_absent_sw = 1'b0, arm_limit_sw = 1'b0, spooler_mode = 1'b0, sprocket_in = 1'b0;
	logic [7:0]  hole_in = 8'h00, arm_pos_l = 8'h00, arm_pos_r = 8'hf0, wind_mag, chan_out;
	logic        start_in, stop_in, adv_req, rev_req, brake_cmd, tape_absent, sprocket_out, strobe_out, running;
	logic [1:0]  reel_en, reel_dir;
	logic [13:0] reel_speed;
	int          fail_count = 0, tests_run = 0, n;
	always #2 clk_sys = ~clk_sys;
	sys_model i_sys_model (.clk_sys, .sprocket_out, .loop_stop, .start_in, .stop_in);
	tape_xport_ctrl #(.STROBE_CYCLES(STRB), .RAMP_STEP(2), .BRAKE_CYCLES(8)) i_tape_xport_ctrl (.clk_sys, .rst,
		.start_in, .stop_in, .fwd_in, .rev_in, .wind_in, .tape_absent_sw, .arm_limit_sw, .spooler_mode, .hole_in,
		.sprocket_in, .arm_pos_l, .arm_pos_r, .adv_req, .rev_req, .brake_cmd, .wind_mag, .tape_absent, .chan_out,
		.sprocket_out, .strobe_out, .reel_en, .reel_dir, .reel_speed, .running);
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic check(input logic [13:0] seen, input logic [13:0] exp);
		tests_run++;
		fail_count += int'(seen !== exp);
		if (seen !== exp) $display("Error at %0t: saw %h want %h", $time, seen, exp);
	endtask
	task automatic test_done();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic go(input logic [1:0] dir);
		{fwd_in, rev_in} = dir;
		i_sys_model.pulse(1'b0);
	endtask
	initial begin
		tick(2);
		rst = 1'b0;
		go(2'b10);
		check({running, adv_req, rev_req}, 3'b110);
		i_sys_model.pulse(1'b1);
		check({running, adv_req, brake_cmd}, 3'b001);
		tick(10);
		go(2'b01);
		check({running, rev_req}, 2'b11);
		{hole_in, sprocket_in} = 9'h14b;
		tick(5);
		check({chan_out, sprocket_out}, 9'h14b);
		for (n = 0; strobe_out === 1'b1 && n < 99; n++) tick(1);
		check(14'(n), 14'(STRB - 2));
		if (n == 99) test_done();
		sprocket_in = 1'b0;
		tick(4);
		// Stop arrives mid-strobe, so the gate must cut it short
		{loop_stop, sprocket_in} = 2'b11;
		tick(9);
		check({running, strobe_out}, 2'b00);
		{loop_stop, sprocket_in, spooler_mode, tape_absent_sw} = 4'b0011;
		tick(12);
		go(2'b10);
		check({running, tape_absent, adv_req, rev_req}, 4'b1100);
		spooler_mode = 1'b0;
		tick(4);
		check({tape_absent, adv_req}, 2'b01);
		{arm_limit_sw, tape_absent_sw} = 2'b10;
		tick(5);
		check(running, 1'b0);
		arm_limit_sw = 1'b0;
		tick(12);
		go(2'b11);
		check({running, adv_req, rev_req}, 3'b100);
		i_sys_model.pulse(1'b1);
		{rev_in, wind_in} = 2'b01;
		tick(30);
		check({running, adv_req, wind_mag > 8'h03}, 3'b011);
		{spooler_mode, arm_pos_l, arm_pos_r} = {1'b1, 8'h05, 8'hf0};
		tick(4);
		check({reel_en, reel_dir}, 4'b1001);
		check(reel_speed, 14'h0800);
		spooler_mode = 1'b0;
		tick(4);
		check(reel_en, 2'b00);
		wind_in = 1'b0;
		tick(6);
		check(wind_mag, 8'h00);
		test_done();
	end
endmodule
